/* hdl/prc_cmd_unit.sv */
// prc_cmd_unit.sv: executes pulse, port and reset configuration sentences
// assumes: sentence framing and checksum are handled upstream; software
// fills the staging words, then writes the command word to execute.
`timescale 1ns/1ps
`include "prc_cfg.svh"

module prc_cmd_unit #(
    parameter logic [31:0] SEC_NS = `PRC_SEC_NS
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [31:0] rdata,
    input wire logic fix_pin,
    input wire logic act_a_pin,
    input wire logic act_b_pin,
    output logic pulse_out,
    output logic resp_valid,
    output prc_pkg::prc_sent_t resp_kind,
    output prc_pkg::prc_baud_t resp_baud,
    output logic resp_err,
    output prc_pkg::prc_baud_t port_baud,
    output logic [2:0] in_proto,
    output logic [2:0] out_proto,
    output logic cold_rst,
    output logic warm_rst,
    output logic hot_rst,
    output logic factory_rst,
    output logic flash_store,
    output logic flash_erase_nav,
    output logic flash_erase_cfg,
    output logic standby
);
    // ----------------------------------------------------------------
    // local constants
    // ----------------------------------------------------------------
    // command letters of the reset sentence
    localparam logic [7:0] CH_COLD = 8'h43;
    localparam logic [7:0] CH_WARM = 8'h57;
    localparam logic [7:0] CH_HOT = 8'h48;
    localparam logic [7:0] CH_FACT = 8'h46;
    localparam logic [7:0] CH_STBY = 8'h53;
    // mode field of the command word
    localparam logic [1:0] MD_QUERY = 2'h0;
    localparam logic [1:0] MD_SET = 2'h1;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [31:0] stg_pulse; // staged pulse word
    logic [31:0] stg_cable; // staged cable offset
    logic [31:0] stg_port; // staged port word
    logic [31:0] stg_reset; // staged reset word
    logic [31:0] stg_secs; // staged standby seconds
    prc_pkg::prc_pmode_t cur_mode; // live pulse mode
    logic [22:0] cur_width; // live width, 100 ns units
    logic cur_pol; // live polarity
    logic [31:0] cur_cable; // live offset, ns
    logic [10:0] pend_port; // port word held between answers
    logic [2:0] wake_en; // wake sources armed
    logic [31:0] secs_left; // standby seconds remaining
    prc_pkg::prc_state_t state;
    logic [2:0] pin_meta; // first sync stage, read by second only
    logic [2:0] pin_sync; // fix, act_a, act_b
    logic sec_tick; // one-second epoch from the pulse gen
    logic [31:0] next_rdata;

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    wire go = wr_stb && (addr == `PRC_A_CMD) && (state == prc_pkg::st_idle);
    wire prc_pkg::prc_sent_t sent = prc_pkg::prc_sent_t'(wdata[`PRC_F_SENT]);
    wire [1:0] cmode = wdata[`PRC_F_MODE];
    wire is_q = cmode == MD_QUERY;
    wire is_s = cmode == MD_SET;
    wire mode_bad = !is_q && !is_s;

    // staged field views
    wire [1:0] s_pmode = stg_pulse[`PRC_F_PMODE];
    wire [22:0] s_width = stg_pulse[`PRC_F_WIDTH];
    wire [2:0] s_inp = stg_port[`PRC_F_INP];
    wire [7:0] s_rcmd = stg_reset[`PRC_F_RCMD];
    wire [2:0] s_fop = stg_reset[`PRC_F_FOP];

    // pulse set validity: mode 0..2, width 1..5000000, offset within 1 s
    wire pulse_ok = (s_pmode != 2'(prc_pkg::pulse_mode_bad)) &&
        (s_width != 23'h00_0000) && (s_width <= `PRC_WIDTH_MAX) &&
        (stg_cable[31] ? (32'(-stg_cable) < SEC_NS) : (stg_cable < SEC_NS));
    // every baud code is legal; only the input mask can be bad
    wire port_ok = s_inp != 3'h0;
    // reset letters
    wire r_cold = s_rcmd == CH_COLD;
    wire r_warm = s_rcmd == CH_WARM;
    wire r_hot = s_rcmd == CH_HOT;
    wire r_fact = s_rcmd == CH_FACT;
    wire r_stby = s_rcmd == CH_STBY;
    wire reset_ok = (r_cold || r_warm || r_hot || r_fact || r_stby) &&
        (s_fop <= `PRC_FOP_MAX);

    // the one decision per command
    wire do_pulse_set = go && (sent == prc_pkg::sent_pulse) && is_s && pulse_ok;
    wire do_pulse_q = go && (sent == prc_pkg::sent_pulse) && is_q;
    wire do_port_set = go && (sent == prc_pkg::sent_port) && is_s && port_ok;
    wire do_port_q = go && (sent == prc_pkg::sent_port) && is_q;
    wire do_reset = go && (sent == prc_pkg::sent_reset) && is_s && reset_ok;
    // anything else that was issued is an error, settings untouched
    wire do_err = go && !(do_pulse_set || do_pulse_q || do_port_set ||
        do_port_q || do_reset);
    // a reset query falls into do_err: it has no query form

    // cold and factory restore the default configuration
    wire cfg_clear = do_reset && (r_cold || r_fact);

    // ----------------------------------------------------------------
    // wake decode
    // ----------------------------------------------------------------
    // sources are independent; any mix may be armed
    wire wake_now = standby && (
        (wake_en[0] && pin_sync[1]) ||
        (wake_en[1] && pin_sync[2]) ||
        (wake_en[2] && (secs_left == 32'h0000_0000)));

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    // unmapped and write-only addresses read as zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (addr)
            `PRC_A_STG_PULSE: next_rdata = stg_pulse;
            `PRC_A_STG_CABLE: next_rdata = stg_cable;
            `PRC_A_STG_PORT: next_rdata = stg_port;
            `PRC_A_STG_RESET: next_rdata = stg_reset;
            `PRC_A_STG_SECS: next_rdata = stg_secs;
            `PRC_A_STATUS: next_rdata = {30'h0000_0000,
                state == prc_pkg::st_port2, standby};
            `PRC_A_CUR_PULSE: begin
                next_rdata[`PRC_F_WIDTH] = cur_width;
                next_rdata[`PRC_F_PMODE] = cur_mode;
                next_rdata[`PRC_F_POL] = cur_pol;
            end
            `PRC_A_CUR_CABLE: next_rdata = cur_cable;
            `PRC_A_CUR_PORT: next_rdata = {21'h00_0000, out_proto, 1'b0,
                in_proto, 2'h0, port_baud};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    // fix and wake activity come from outside the clock domain
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
        end else begin
            pin_meta <= {act_b_pin, act_a_pin, fix_pin};
            pin_sync <= pin_meta;
        end
    end

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    // read data stand one cycle only, zero otherwise
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
        end else begin
            rdata <= rd_stb ? next_rdata : 32'h0000_0000;
        end
    end

    // staging words: plain storage, no effect until a command
    always_ff @(posedge core_clk) begin
        if (rst) begin
            stg_pulse <= 32'h0000_0000;
            stg_cable <= 32'h0000_0000;
            stg_port <= 32'h0000_0000;
            stg_reset <= 32'h0000_0000;
            stg_secs <= 32'h0000_0000;
        end else if (wr_stb) begin
            unique case (addr)
                `PRC_A_STG_PULSE: stg_pulse <= wdata;
                `PRC_A_STG_CABLE: stg_cable <= wdata;
                `PRC_A_STG_PORT: stg_port <= wdata;
                `PRC_A_STG_RESET: stg_reset <= wdata;
                `PRC_A_STG_SECS: stg_secs <= wdata;
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // pulse configuration
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst || cfg_clear) begin
            cur_mode <= prc_pkg::prc_pmode_t'(`PRC_RV_PMODE);
            cur_width <= `PRC_RV_WIDTH;
            cur_pol <= `PRC_RV_POL;
            cur_cable <= `PRC_RV_CABLE;
        end else if (do_pulse_set) begin
            cur_mode <= prc_pkg::prc_pmode_t'(s_pmode);
            cur_width <= s_width;
            cur_pol <= stg_pulse[`PRC_F_POL];
            cur_cable <= stg_cable;
        end
    end

    // ----------------------------------------------------------------
    // port configuration and the two-answer sequence
    // ----------------------------------------------------------------
    // the new port word is latched at the command so a staging
    // write in between cannot change what gets applied
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= prc_pkg::st_idle;
            pend_port <= 11'h000;
            port_baud <= prc_pkg::prc_baud_t'(`PRC_RV_BAUD);
            in_proto <= `PRC_RV_INP;
            out_proto <= `PRC_RV_OUTP;
        end else if (cfg_clear) begin
            state <= prc_pkg::st_idle;
            port_baud <= prc_pkg::prc_baud_t'(`PRC_RV_BAUD);
            in_proto <= `PRC_RV_INP;
            out_proto <= `PRC_RV_OUTP;
        end else begin
            unique case (state)
                prc_pkg::st_idle: begin
                    if (do_port_set) begin
                        pend_port <= stg_port[10:0];
                        state <= prc_pkg::st_port2;
                    end
                end
                prc_pkg::st_port2: begin
                    // switch over as the second answer leaves
                    port_baud <= prc_pkg::prc_baud_t'(pend_port[`PRC_F_BAUD]);
                    in_proto <= pend_port[`PRC_F_INP];
                    out_proto <= pend_port[`PRC_F_OUTP];
                    state <= prc_pkg::st_idle;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // answers
    // ----------------------------------------------------------------
    // one answer per good command; port set gives two, old then new
    always_ff @(posedge core_clk) begin
        if (rst) begin
            resp_valid <= 1'b0;
            resp_kind <= prc_pkg::sent_none;
            resp_baud <= prc_pkg::baud_4800;
            resp_err <= 1'b0;
        end else begin
            resp_valid <= 1'b0;
            resp_err <= 1'b0;
            resp_baud <= port_baud;
            if (state == prc_pkg::st_port2) begin
                resp_valid <= 1'b1;
                resp_kind <= prc_pkg::sent_port;
                resp_baud <= prc_pkg::prc_baud_t'(pend_port[`PRC_F_BAUD]);
            end else if (do_err) begin
                resp_err <= 1'b1;
                resp_kind <= mode_bad ? prc_pkg::sent_none : sent;
            end else if (go) begin
                // query, set or reset: answered at the present rate
                resp_valid <= 1'b1;
                resp_kind <= sent;
            end
        end
    end

    // ----------------------------------------------------------------
    // reset sentence actions
    // ----------------------------------------------------------------
    // one-cycle strobes toward the receiver's memory and restart logic
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cold_rst <= 1'b0;
            warm_rst <= 1'b0;
            hot_rst <= 1'b0;
            factory_rst <= 1'b0;
            flash_store <= 1'b0;
            flash_erase_nav <= 1'b0;
            flash_erase_cfg <= 1'b0;
        end else begin
            cold_rst <= do_reset && r_cold;
            warm_rst <= do_reset && r_warm;
            hot_rst <= do_reset && r_hot;
            factory_rst <= do_reset && r_fact;
            // codes 0 and 1 do nothing; factory erases everything too
            flash_store <= do_reset && (s_fop == 3'h2 || s_fop == 3'h3);
            flash_erase_nav <= do_reset && (r_fact || s_fop == 3'h4 ||
                s_fop == 3'h6);
            flash_erase_cfg <= do_reset && (r_fact || s_fop == 3'h5 ||
                s_fop == 3'h6);
        end
    end

    // ----------------------------------------------------------------
    // standby and timed wake
    // ----------------------------------------------------------------
    // with no source armed the unit sleeps until the next reset
    always_ff @(posedge core_clk) begin
        if (rst) begin
            standby <= 1'b0;
            wake_en <= 3'h0;
            secs_left <= 32'h0000_0000;
        end else if (do_reset && r_stby) begin
            standby <= 1'b1;
            wake_en <= stg_reset[`PRC_F_WAKE];
            secs_left <= stg_secs;
        end else if (wake_now) begin
            standby <= 1'b0;
        end else if (standby && sec_tick && secs_left != 32'h0000_0000) begin
            secs_left <= secs_left - 32'h0000_0001;
        end
    end

    // ----------------------------------------------------------------
    // pulse generator
    // ----------------------------------------------------------------
    prc_pulse_gen #(
        .SEC_NS(SEC_NS)
    ) u_pulse (
        .core_clk(core_clk),
        .rst(rst),
        .mode(cur_mode),
        .width(cur_width),
        .pol(cur_pol),
        .cable(cur_cable),
        .fix(pin_sync[0]),
        .pulse_out(pulse_out),
        .sec_tick(sec_tick)
    );

endmodule : prc_cmd_unit

/* hdl/prc_cfg.svh */
// prc_cfg.svh: register offsets, field positions, reset values, timing
// assumes: included by bare name from every design file that needs it
`ifndef PRC_CFG_SVH
`define PRC_CFG_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------
`define PRC_A_CMD 8'h00
`define PRC_A_STG_PULSE 8'h04
`define PRC_A_STG_CABLE 8'h08
`define PRC_A_STG_PORT 8'h0C
`define PRC_A_STG_RESET 8'h10
`define PRC_A_STG_SECS 8'h14
`define PRC_A_STATUS 8'h18
`define PRC_A_CUR_PULSE 8'h1C
`define PRC_A_CUR_CABLE 8'h20
`define PRC_A_CUR_PORT 8'h24

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PRC_F_SENT 1:0
`define PRC_F_MODE 3:2
`define PRC_F_WIDTH 22:0
`define PRC_F_PMODE 25:24
`define PRC_F_POL 28
`define PRC_F_BAUD 1:0
`define PRC_F_INP 6:4
`define PRC_F_OUTP 10:8
`define PRC_F_RCMD 7:0
`define PRC_F_FOP 10:8
`define PRC_F_WAKE 14:12

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define PRC_RV_PMODE 2'h1
`define PRC_RV_WIDTH 23'h00_002A
`define PRC_RV_POL 1'h1
`define PRC_RV_CABLE 32'h0000_0000
`define PRC_RV_BAUD 2'h0
`define PRC_RV_INP 3'h4
`define PRC_RV_OUTP 3'h4
`define PRC_WIDTH_MAX 23'h4C_4B40
`define PRC_FOP_MAX 3'h6

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PRC_CLK_HZ 25000000
`define PRC_SEC_NS 1000000000
`define PRC_TICK_NS 100

`endif

/* hdl/prc_pkg.sv */
// prc_pkg.sv: types shared by the command unit and its pulse generator
// assumes: nothing; every use is written prc_pkg::name
package prc_pkg;

    // sentence selector written into the command word
    typedef enum logic [1:0] {
        sent_pulse,
        sent_port,
        sent_reset,
        sent_none
    } prc_sent_t;

    // pulse modes
    typedef enum logic [1:0] {
        pulse_always_off,
        pulse_always_on,
        pulse_fix_gated,
        pulse_mode_bad
    } prc_pmode_t;

    // baud codes: 4800, 9600, 19200, 38400
    typedef enum logic [1:0] {
        baud_4800,
        baud_9600,
        baud_19200,
        baud_38400
    } prc_baud_t;

    // command sequencer
    typedef enum logic {
        st_idle,
        st_port2
    } prc_state_t;

endpackage : prc_pkg

/* hdl/prc_pulse_gen.sv */
// prc_pulse_gen.sv: once-per-second timing pulse generator
// assumes: settings are already validated and held stable by the caller
`timescale 1ns/1ps
`include "prc_cfg.svh"

module prc_pulse_gen #(
    parameter logic [31:0] SEC_NS = `PRC_SEC_NS
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire prc_pkg::prc_pmode_t mode,
    input wire logic [22:0] width,
    input wire logic pol,
    input wire logic [31:0] cable,
    input wire logic fix,
    output logic pulse_out,
    output logic sec_tick
);
    // ns advanced per clock, derived from the clock rate
    localparam logic [31:0] STEP_NS = 32'(`PRC_SEC_NS / `PRC_CLK_HZ);

    logic [31:0] ns; // position within the second, in ns
    logic [31:0] start_ns; // pulse start after offset
    logic [31:0] width_ns; // width in 100 ns ticks, as ns
    logic [31:0] since; // ns elapsed since pulse start
    logic active; // pulse asserted, before polarity
    logic [31:0] next_ns;
    logic wrap;

    // ----------------------------------------------------------------
    // offset and width arithmetic
    // ----------------------------------------------------------------
    // negative offset wraps into the previous second: pulse comes early
    assign start_ns = cable[31] ? SEC_NS + cable : cable;
    assign width_ns = 32'(width) * 32'(`PRC_TICK_NS);
    assign since = (ns >= start_ns) ? ns - start_ns : ns + SEC_NS - start_ns;
    assign wrap = ns >= SEC_NS - STEP_NS;
    assign next_ns = wrap ? 32'h0000_0000 : ns + STEP_NS;

    // gate by mode; fix-gated needs a valid position
    assign active = (since < width_ns) &&
        ((mode == prc_pkg::pulse_always_on) ||
        ((mode == prc_pkg::pulse_fix_gated) && fix));

    // ----------------------------------------------------------------
    // epoch counter and output flop
    // ----------------------------------------------------------------
    // 40 ns steps divide 1 s exactly, so the epoch never drifts
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ns <= 32'h0000_0000;
            sec_tick <= 1'b0;
            pulse_out <= 1'b0;
        end else begin
            ns <= next_ns;
            sec_tick <= wrap;
            pulse_out <= pol ? active : ~active;
        end
    end

endmodule : prc_pulse_gen

/* testbench/prc_cmd_sva.sv */
// prc_cmd_sva.sv: port-level checks of the command unit
// assumes: bound to prc_cmd_unit, one clock, synchronous reset
`timescale 1ns/1ps
module prc_cmd_sva (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic resp_valid,
    input wire prc_pkg::prc_sent_t resp_kind,
    input wire prc_pkg::prc_baud_t resp_baud,
    input wire logic resp_err,
    input wire prc_pkg::prc_baud_t port_baud,
    input wire logic [2:0] in_proto,
    input wire logic pulse_out,
    input wire logic cold_rst,
    input wire logic warm_rst,
    input wire logic hot_rst,
    input wire logic factory_rst,
    input wire logic flash_store,
    input wire logic flash_erase_nav,
    input wire logic flash_erase_cfg,
    input wire logic standby
);
    // ----
    // helper: port set taken last cycle
    // ----
    logic pset_q; // good or bad port set seen
    wire pend = pset_q && resp_valid; // second answer owed, command refused
    always_ff @(posedge core_clk) begin
        pset_q <= !rst && wr_stb && addr == 8'h00 && wdata[3:0] == 4'h5;
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // first answer of a port set: old baud on the wire
    sequence s_port_first;
        pend && resp_kind == prc_pkg::sent_port && resp_baud == port_baud;
    endsequence
    AST_PORT_PAIR: assert property (s_port_first |-> ##1 resp_valid ##1
        port_baud == $past(resp_baud)) else $error("port set answer pair wrong");
    AST_ERR_ONLY: assert property (resp_err |-> !resp_valid ##1
        $stable(port_baud) && $stable(in_proto)) else $error("error answer changed port");
    AST_IN_MASK: assert property (in_proto != 3'h0)
        else $error("input mask zero");
    AST_CMD_ANSWER: assert property (wr_stb && addr == 8'h00 && !pend |=>
        resp_valid != resp_err) else $error("command not answered once");
    // default pulse after release: about 105 cycles high, slack of one each end
    AST_BOOT_PULSE: assert property ($fell(rst) |-> ##2 pulse_out[*8] ##95
        pulse_out ##3 !pulse_out) else $error("default pulse width wrong");
    AST_COLD_DEFAULT: assert property (cold_rst || factory_rst |=>
        port_baud == prc_pkg::baud_4800 && in_proto == 3'h4) else $error("no defaults");
    AST_SOFT_RESET: assert property (warm_rst || hot_rst |-> resp_valid &&
        !cold_rst && !factory_rst) else $error("soft reset pulse wrong");
    AST_FACTORY_FLASH: assert property (factory_rst |->
        flash_erase_nav && flash_erase_cfg) else $error("factory reset kept flash");
    AST_FLASH_ANSWER: assert property (flash_store || flash_erase_nav ||
        flash_erase_cfg |-> resp_valid && resp_kind == prc_pkg::sent_reset)
        else $error("flash strobe without answer");
    AST_STANDBY_IN: assert property ($rose(standby) |-> resp_valid &&
        resp_kind == prc_pkg::sent_reset) else $error("standby without command");
endmodule : prc_cmd_sva

bind prc_cmd_unit prc_cmd_sva i_sva (.core_clk, .rst, .addr, .wdata, .wr_stb,
    .resp_valid, .resp_kind, .resp_baud, .resp_err, .port_baud, .in_proto, .pulse_out,
    .cold_rst, .warm_rst, .hot_rst, .factory_rst, .flash_store, .flash_erase_nav,
    .flash_erase_cfg, .standby);

/* testbench/prc_host_model.sv */
// prc_host_model.sv: host on the serial ports, counts answer sentences
// assumes: bench raises talk_a or talk_b to send traffic
`timescale 1ns/1ps
module prc_host_model (
    input wire logic core_clk,
    input wire logic resp_valid,
    input wire logic talk_a,
    input wire logic talk_b,
    output logic act_a_pin,
    output logic act_b_pin,
    output int n_ans
);
    // idle line shows no activity; only real traffic can wake the device through a port
    assign act_a_pin = talk_a;
    assign act_b_pin = talk_b;
    initial n_ans = 0;
    // one count per answer sentence heard
    always @(posedge core_clk) begin
        if (resp_valid) n_ans <= n_ans + 1;
    end
endmodule : prc_host_model

/* testbench/pulse_port_reset_cmd_unit_tb.sv */
// pulse_port_reset_cmd_unit_tb.sv: self-checking bench for the command unit
// assumes: checker bound in its own file, host model drives activity pins
`timescale 1ns/1ps
module pulse_port_reset_cmd_unit_tb;
    logic core_clk = 0, rst = 1, wr_stb = 0, rd_stb = 0, fix_pin = 0, talk_a = 0, talk_b = 0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata, got, pw;
    logic resp_valid, resp_err, standby, cold_rst, warm_rst, hot_rst, factory_rst;
    logic flash_store, flash_erase_nav, flash_erase_cfg, act_a_pin, act_b_pin, pulse_out;
    prc_pkg::prc_sent_t resp_kind;
    prc_pkg::prc_baud_t resp_baud, port_baud;
    logic [2:0] in_proto, out_proto;
    int err_total = 0, n_compared = 0, seed = 32'h0000_627b, n_ans, pn, n;
    logic [31:0] m_pulse = 32'h1100_002A, m_port = 32'h0000_0440; // model state
    logic [9:0] seen; // answer-cycle snapshot
    logic [7:0] lt[9] = '{"H", "W", "W", "H", "H", "C", "F", "H", "Q"};
    logic [2:0] op[9] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h0, 3'h1, 3'h7, 3'h0};
    logic [9:0] ex[9] = '{10'h114, 10'h124, 10'h122, 10'h111, 10'h113, 10'h140, 10'h10B,
        10'h200, 10'h200};
    always #20 core_clk = ~core_clk;
    prc_cmd_unit #(.SEC_NS(32'h0000_9C40)) i_dut (.core_clk, .rst, .addr, .wdata, .wr_stb,
        .rd_stb, .rdata, .fix_pin, .act_a_pin, .act_b_pin, .pulse_out, .resp_valid,
        .resp_kind, .resp_baud, .resp_err, .port_baud, .in_proto, .out_proto, .cold_rst,
        .warm_rst, .hot_rst, .factory_rst, .flash_store, .flash_erase_nav,
        .flash_erase_cfg, .standby);
    prc_host_model i_host (.core_clk, .resp_valid, .talk_a, .talk_b, .act_a_pin,
        .act_b_pin, .n_ans);
    // ----
    // bus cycles and comparison
    // ----
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("ERROR %0t: saw %h expected %h", $time, s, e);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1;
        @(posedge core_clk);
        wr_stb <= 0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        rd_stb <= 1;
        @(posedge core_clk);
        rd_stb <= 0;
        @(posedge core_clk);
        d = rdata;
    endtask : rd
    // command write, then snapshot of the answer cycle
    task cmd(input logic [3:0] c);
        wr(8'h00, {28'h000_0000, c});
        #1 seen = {resp_err, resp_valid, standby, cold_rst, warm_rst, hot_rst, factory_rst,
            flash_store, flash_erase_nav, flash_erase_cfg};
    endtask : cmd
    task results;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results
    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 0;
        repeat (120) @(posedge core_clk);
        rd(8'h1C, got);
        chk(got, m_pulse);
        rd(8'h20, got);
        chk(got, 32'h0000_0000);
        // modes 0..2 good, then bad mode, zero width, width one past the top
        for (int i = 0; i < 6; i++) begin
            pw = {3'h0, 1'($random(seed)), 2'h0, i == 3 ? 2'h3 : 2'(i % 3), 1'h0,
                i == 4 ? 23'h0 : i == 5 ? 23'h4C_4B41 : 23'(1 + {$random(seed)} % 5000000)};
            fix_pin <= 1'($random(seed));
            wr(8'h04, pw);
            wr(8'h08, 32'hFFFF_FFD8); // 40 ns early
            cmd(4'h4);
            if (i < 3) m_pulse = pw;
            chk(seen, i < 3 ? 10'h100 : 10'h200);
            rd(8'h1C, got);
            chk(got, m_pulse);
        end
        rd(8'h20, got);
        chk(got, 32'hFFFF_FFD8);
        // every baud, one output protocol each, last case a zero input mask
        for (int b = 0; b < 5; b++) begin
            pw = {21'h0, 3'h1 << (b % 3), 1'h0, b == 4 ? 3'h0 : 3'(b + 1), 2'h0, 2'(b)};
            wr(8'h0C, pw);
            pn = n_ans;
            cmd(4'h5);
            repeat (3) @(posedge core_clk);
            if (b < 4) m_port = pw;
            chk(n_ans - pn, b < 4 ? 2 : 0);
            chk(seen, b < 4 ? 10'h100 : 10'h200);
            rd(8'h24, got);
            chk(got, m_port);
        end
        // reset letters with flash codes; cold puts defaults back
        for (int k = 0; k < 9; k++) begin
            wr(8'h10, {17'h0, 3'h0, 1'h0, op[k], lt[k]});
            cmd(4'h6);
            chk(seen, ex[k]);
            if (k == 5) m_port = 32'h0000_0440;
            rd(8'h24, got);
            chk(got, m_port);
        end
        rd(8'h1C, got);
        chk(got, 32'h1100_002A);
        rd(8'h20, got);
        chk(got, 32'h0000_0000);
        cmd(4'h2);
        chk(seen, 10'h200);
        // wake by port A, port B, time zero, then two seconds
        for (int w = 0; w < 4; w++) begin
            wr(8'h14, w == 3 ? 32'h0000_0002 : 32'h0000_0000);
            wr(8'h10, {17'h0, w > 1 ? 3'h4 : 3'h1 << w, 4'h0, 8'h53});
            cmd(4'h6);
            chk(seen, 10'h180);
            talk_a <= w == 0;
            talk_b <= w == 1;
            n = 0;
            while (standby === 1'b1 && n < 3000) begin
                @(posedge core_clk);
                n++;
            end
            chk({standby, 1'(n > 500)}, {1'b0, 1'(w == 3)});
            if (n >= 3000) results();
            talk_a <= 0;
            talk_b <= 0;
        end
        results();
    end
endmodule : pulse_port_reset_cmd_unit_tb
